// ---- rtl/diag_slave.sv ----
// Slave end: command interpreter for test output, alarms, history and monitors
//
// Function
// RQ1: Test command with 0004 enters forced output.
// RQ2: Master disables inputs before forced output.
// RQ3: Forced mode drives pins regardless of servo.
// RQ4: Output command A0 maps bits 0..8.
// RQ5: Test command with 0000 cancels test mode.
// RQ6: History keeps sixteen alarm numbers, 00FF empty.
// RQ7: Data numbers 40..4F return detail numbers.
// RQ8: Data numbers 20..2F return occurrence hours.
// RQ9: New alarm pushes history, shifting all entries.
// RQ10: Master reads history preferably during servo-off.
// RQ11: Clear 20 with key erases history.
// RQ12: Current alarm read returns number or 00FF.
// RQ13: Data number 03 returns number and detail.
// RQ14: Snapshot read returns value with processing info.
// RQ15: Reset 00 with key clears active alarm.
// RQ16: Version read returns firmware string.
// RQ17: Data number 90 returns motor pulse position.
// RQ18: Data number 91 returns command unit position.
// RQ19: Silence 0.5 s in test mode stops motor.
// RQ20: Input disable forces inputs off, safety excluded.
// RQ21: Output command refused outside forced mode.
`timescale 1ns/100ps
module diag_slave #(
	parameter int WDOG_CYCLES = diag_pkg::WDOG_CYC,
	parameter logic [31:0] VERSION_WORD = 32'h0000_0A01 // Arbitrary value
) (
	input wire logic clk_sys,
	input wire logic nrst,
	diag_if.slave link,
	input wire logic alarm_event,
	input wire logic [15:0] alarm_num,
	input wire logic [15:0] alarm_detail,
	input wire logic [15:0] run_hours,
	input wire logic [31:0] snap_word [diag_pkg::SNAP_ITEMS],
	input wire logic [31:0] pos_pulse,
	input wire logic [31:0] pos_unit,
	output logic [diag_pkg::OUT_PINS-1:0] io_connector,
	output logic forced_mode,
	output logic inputs_disabled,
	output logic alarm_clear_input,
	output logic stop_lock,
	output logic [15:0] active_alarm
);
	import diag_pkg::*;

	logic [15:0] hist_num_q [HIST_DEPTH];
	logic [15:0] hist_det_q [HIST_DEPTH];
	logic [15:0] hist_hrs_q [HIST_DEPTH];
	logic [31:0] snap_q [SNAP_ITEMS];
	logic [15:0] active_det_q;
	logic [31:0] wdog_q;
	logic in_test_q;
	logic take;
	logic key_ok;
	logic hist_clr;
	logic alm_rst;
	logic [3:0] lo;
	logic [3:0] hi;

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	assign take = link.req_valid;
	assign key_ok = (link.req_data == KEY_1EA5);
	assign hist_clr = take && link.req_cmd == CMD_CLEAR && link.req_dn == DN_HIST_CLR && key_ok;
	assign alm_rst = take && link.req_cmd == CMD_CLEAR && link.req_dn == DN_ZERO && key_ok;
	assign lo = link.req_dn[3:0];
	assign hi = link.req_dn[7:4];

	// ----------------------------------------------------------------
	// Test mode selection
	// ----------------------------------------------------------------
	// Any nonzero selection counts as test operation for the watchdog
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			forced_mode <= 1'b0;
			in_test_q <= 1'b0;
		end else if (take && link.req_cmd == CMD_TEST && link.req_dn == DN_ZERO) begin
			forced_mode <= (link.req_data == TEST_DO); // [RQ1] [RQ5]
			in_test_q <= (link.req_data != TEST_OFF); // [RQ5]
		end
	end

	// Output pins follow the last accepted word only in forced mode
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			io_connector <= '0;
		end else if (!forced_mode) begin
			io_connector <= '0;
		end else if (take && link.req_cmd == CMD_OUT_SET && link.req_dn == DN_OUT_PINS) begin
			io_connector <= link.req_data[OUT_PINS-1:0]; // [RQ3] [RQ4]
		end
	end

	// Input disable and enable, master's duty to do first
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			inputs_disabled <= 1'b0;
		end else if (take && link.req_cmd == CMD_IN_DIS && key_ok) begin
			if (link.req_dn == DN_IN_DIS) begin
				inputs_disabled <= 1'b1; // [RQ20] [RQ2]
			end else if (link.req_dn == DN_IN_EN) begin
				inputs_disabled <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Communication watchdog
	// ----------------------------------------------------------------
	// Lock stays until test mode leaves; a late command does not restart motion
	always_ff @(posedge clk_sys) begin
		if (!nrst || !in_test_q) begin
			wdog_q <= '0;
			stop_lock <= 1'b0;
		end else if (take) begin
			wdog_q <= '0;
		end else if (wdog_q >= 32'(WDOG_CYCLES - 1)) begin
			stop_lock <= 1'b1; // [RQ19]
		end else begin
			wdog_q <= wdog_q + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Active alarm and reset
	// ----------------------------------------------------------------
	// A new alarm in the reset cycle wins over the clear
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			active_alarm <= NO_ALARM;
			active_det_q <= '0;
			alarm_clear_input <= 1'b0;
		end else begin
			alarm_clear_input <= alm_rst; // [RQ15]
			if (alarm_event) begin
				active_alarm <= alarm_num;
				active_det_q <= alarm_detail;
			end else if (alm_rst) begin
				active_alarm <= NO_ALARM; // [RQ15]
				active_det_q <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// History and snapshot
	// ----------------------------------------------------------------
	// Push beats clear at entry 0 while clear empties the older entries, so the new alarm is never lost
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_num_q[i] <= NO_ALARM;
				hist_det_q[i] <= '0;
				hist_hrs_q[i] <= '0;
			end
		end else if (alarm_event) begin
			hist_num_q[0] <= alarm_num; // [RQ9]
			hist_det_q[0] <= alarm_detail;
			hist_hrs_q[0] <= run_hours;
			for (int i = 1; i < HIST_DEPTH; i++) begin
				hist_num_q[i] <= hist_clr ? NO_ALARM : hist_num_q[i-1];
				hist_det_q[i] <= hist_clr ? 16'h0000 : hist_det_q[i-1];
				hist_hrs_q[i] <= hist_clr ? 16'h0000 : hist_hrs_q[i-1];
			end
		end else if (hist_clr) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_num_q[i] <= NO_ALARM; // [RQ11]
				hist_det_q[i] <= '0;
				hist_hrs_q[i] <= '0;
			end
		end
	end

	// Status captured at the alarm edge
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int i = 0; i < SNAP_ITEMS; i++) begin
				snap_q[i] <= '0;
			end
		end else if (alarm_event) begin
			for (int i = 0; i < SNAP_ITEMS; i++) begin
				snap_q[i] <= snap_word[i]; // [RQ14]
			end
		end
	end

	// ----------------------------------------------------------------
	// Answer path
	// ----------------------------------------------------------------
	// One answer per request, exactly one cycle later
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			link.rsp_valid <= 1'b0;
			link.rsp_data <= '0;
			link.rsp_status <= RESP_OK;
		end else begin
			link.rsp_valid <= take;
			link.rsp_data <= '0;
			link.rsp_status <= RESP_OK;
			if (take) begin
				case (link.req_cmd)
					CMD_RD_HIST: begin
						if (hi == GRP_NUM || hi == GRP_NUM_HI) begin
							link.rsp_data <= {16'h0000, hist_num_q[lo]}; // [RQ6]
						end else if (hi == GRP_DET) begin
							link.rsp_data <= {16'h0000, hist_det_q[lo]}; // [RQ7]
						end else if (hi == GRP_TIME) begin
							link.rsp_data <= {16'h0000, hist_hrs_q[lo]}; // [RQ8]
						end else begin
							link.rsp_status <= RESP_BAD;
						end
					end
					CMD_RD_ALARM: begin
						if (link.req_dn == DN_ZERO) begin
							link.rsp_data <= {16'h0000, active_alarm}; // [RQ12]
						end else if (link.req_dn == DN_ALM_DET) begin
							link.rsp_data <= (active_alarm == NO_ALARM) ? NO_ALARM_DET
								: {active_alarm, active_det_q}; // [RQ13]
						end else if (link.req_dn == DN_VERSION) begin
							link.rsp_data <= VERSION_WORD; // [RQ16]
						end else if (link.req_dn == DN_POS_PULSE) begin
							link.rsp_data <= pos_pulse; // [RQ17]
						end else if (link.req_dn == DN_POS_UNIT) begin
							link.rsp_data <= pos_unit; // [RQ18]
						end else begin
							link.rsp_status <= RESP_BAD;
						end
					end
					CMD_RD_SNAP: begin
						if (hi == GRP_SNAP_A && lo <= SNAP_A_LAST) begin
							link.rsp_data <= snap_q[lo]; // [RQ14]
						end else if (hi == GRP_SNAP_B && lo <= SNAP_B_LAST) begin
							link.rsp_data <= snap_q[5'(lo) + 5'd15]; // [RQ14]
						end else begin
							link.rsp_status <= RESP_BAD;
						end
					end
					CMD_OUT_SET: begin
						if (link.req_dn == DN_OUT_PINS && !forced_mode) begin
							link.rsp_status <= RESP_REFUSED; // [RQ21]
						end
					end
					CMD_CLEAR, CMD_TEST, CMD_IN_DIS: begin
						link.rsp_status <= RESP_OK;
					end
					default: begin
						link.rsp_status <= RESP_BAD;
					end
				endcase
			end
		end
	end
endmodule

// ---- rtl/diag_pkg.sv ----
// Shared command codes, data numbers, keys and timing for the diagnostic command link
package diag_pkg;
	localparam logic [7:0] CMD_RD_ALARM = 8'h02;
	localparam logic [7:0] CMD_RD_HIST = 8'h33;
	localparam logic [7:0] CMD_RD_SNAP = 8'h35;
	localparam logic [7:0] CMD_CLEAR = 8'h82;
	localparam logic [7:0] CMD_TEST = 8'h8B;
	localparam logic [7:0] CMD_IN_DIS = 8'h90;
	localparam logic [7:0] CMD_OUT_SET = 8'h92;
	localparam logic [7:0] DN_ZERO = 8'h00;
	localparam logic [7:0] DN_ALM_DET = 8'h03;
	localparam logic [7:0] DN_IN_DIS = 8'h00;
	localparam logic [7:0] DN_IN_EN = 8'h10;
	localparam logic [7:0] DN_HIST_CLR = 8'h20;
	localparam logic [7:0] DN_VERSION = 8'h70;
	localparam logic [7:0] DN_POS_PULSE = 8'h90;
	localparam logic [7:0] DN_POS_UNIT = 8'h91;
	localparam logic [7:0] DN_OUT_PINS = 8'hA0;
	localparam logic [3:0] GRP_NUM = 4'h0;
	localparam logic [3:0] GRP_NUM_HI = 4'h1;
	localparam logic [3:0] GRP_TIME = 4'h2;
	localparam logic [3:0] GRP_DET = 4'h4;
	localparam logic [3:0] GRP_SNAP_A = 4'h8;
	localparam logic [3:0] GRP_SNAP_B = 4'hA;
	localparam logic [3:0] SNAP_A_LAST = 4'hE;
	localparam logic [3:0] SNAP_B_LAST = 4'h9;
	localparam logic [31:0] KEY_1EA5 = 32'h0000_1EA5;
	localparam logic [31:0] TEST_DO = 32'h0000_0004;
	localparam logic [31:0] TEST_OFF = 32'h0000_0000;
	localparam logic [15:0] NO_ALARM = 16'h00FF;
	localparam logic [31:0] NO_ALARM_DET = 32'h00FF_0000;
	localparam int HIST_DEPTH = 16;
	localparam int SNAP_ITEMS = 25;
	localparam int OUT_PINS = 9;
	localparam int CLK_MHZ = 100;
	localparam int WDOG_MS = 500;
	localparam int WDOG_CYC = WDOG_MS * 1000 * CLK_MHZ;
	typedef enum logic [1:0] {
		RESP_OK,
		RESP_REFUSED,
		RESP_BAD
	} resp_t;
endpackage

// ---- rtl/diag_if.sv ----
// Command and answer link between master and slave ends
`timescale 1ns/100ps
interface diag_if;
	logic req_valid;
	logic [7:0] req_cmd;
	logic [7:0] req_dn;
	logic [31:0] req_data;
	logic rsp_valid;
	logic [31:0] rsp_data;
	logic [1:0] rsp_status;
	modport master (output req_valid, req_cmd, req_dn, req_data,
		input rsp_valid, rsp_data, rsp_status);
	modport slave (input req_valid, req_cmd, req_dn, req_data,
		output rsp_valid, rsp_data, rsp_status);
endinterface

// ---- rtl/diag_master.sv ----
// Master end: turns user requests into link commands, enforcing input disable before forced output
`timescale 1ns/100ps
module diag_master (
	input wire logic clk_sys,
	input wire logic nrst,
	diag_if.master link,
	input wire logic user_valid,
	input wire logic [7:0] user_cmd,
	input wire logic [7:0] user_dn,
	input wire logic [31:0] user_data,
	output logic user_ready,
	output logic ans_valid,
	output logic [31:0] ans_data,
	output logic [1:0] ans_status
);
	import diag_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PRE,
		ST_WAIT
	} mst_t;

	mst_t st_q;
	logic [7:0] cmd_q;
	logic [7:0] dn_q;
	logic [31:0] data_q;
	logic is_do;

	assign is_do = user_cmd == CMD_TEST && user_dn == DN_ZERO && user_data == TEST_DO;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Forced output selection is preceded by input disable [RQ2] [RQ1]
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st_q <= ST_IDLE;
			user_ready <= 1'b0;
			link.req_valid <= 1'b0;
			link.req_cmd <= '0;
			link.req_dn <= '0;
			link.req_data <= '0;
			cmd_q <= '0;
			dn_q <= '0;
			data_q <= '0;
			ans_valid <= 1'b0;
			ans_data <= '0;
			ans_status <= '0;
		end else begin
			link.req_valid <= 1'b0;
			ans_valid <= 1'b0;
			user_ready <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					user_ready <= 1'b1;
					if (user_valid && user_ready) begin
						user_ready <= 1'b0;
						cmd_q <= user_cmd;
						dn_q <= user_dn;
						data_q <= user_data;
						link.req_valid <= 1'b1;
						if (is_do) begin
							link.req_cmd <= CMD_IN_DIS;
							link.req_dn <= DN_IN_DIS;
							link.req_data <= KEY_1EA5;
							st_q <= ST_PRE;
						end else begin
							link.req_cmd <= user_cmd;
							link.req_dn <= user_dn;
							link.req_data <= user_data;
							st_q <= ST_WAIT;
						end
					end
				end
				ST_PRE: begin
					// Disable answer is swallowed; then the real selection goes out
					if (link.rsp_valid) begin
						link.req_valid <= 1'b1;
						link.req_cmd <= cmd_q;
						link.req_dn <= dn_q;
						link.req_data <= data_q;
						st_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (link.rsp_valid) begin
						ans_valid <= 1'b1;
						ans_data <= link.rsp_data;
						ans_status <= link.rsp_status;
						st_q <= ST_IDLE;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// ---- dv/servo_diag_command_handler_asserts.sv ----
// Link checker for the diagnostic command path between master and slave ends
`timescale 1ns/100ps
module servo_diag_command_handler_asserts (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic req_valid,
	input wire logic [7:0] req_cmd,
	input wire logic [7:0] req_dn,
	input wire logic [31:0] req_data,
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_data,
	input wire logic [1:0] rsp_status
);
	import diag_pkg::*;
	logic frc_q;
	logic dis_q;
	wire sel_do = req_valid && req_cmd == CMD_TEST && req_dn == DN_ZERO && req_data == TEST_DO;
	wire out_cmd = req_valid && req_cmd == CMD_OUT_SET && req_dn == DN_OUT_PINS;
	wire snap_in = (req_dn[7:4] == GRP_SNAP_A && req_dn[3:0] <= SNAP_A_LAST) ||
		(req_dn[7:4] == GRP_SNAP_B && req_dn[3:0] <= SNAP_B_LAST);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// ----------------
	// Shadow state
	// ----------------
	// Forced mode as seen on the wire, so refusals can be judged
	always_ff @(posedge clk_sys) begin
		if (!nrst) frc_q <= 1'b0;
		else if (req_valid && req_cmd == CMD_TEST && req_dn == DN_ZERO) frc_q <= req_data == TEST_DO;
	end
	// Was the last request an input disable
	always_ff @(posedge clk_sys) begin
		if (!nrst) dis_q <= 1'b0;
		else if (req_valid) dis_q <= req_cmd == CMD_IN_DIS && req_dn == DN_IN_DIS && req_data == KEY_1EA5;
	end
	// ----------------
	// Properties
	// ----------------
	property p_ans; req_valid |=> rsp_valid; endproperty
	a_ans: assert property (p_ans) else $error("answer missing");
	property p_cause; rsp_valid |-> $past(req_valid); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_dis; sel_do |-> dis_q; endproperty
	a_dis: assert property (p_dis) else $error("forced output without input disable");
	property p_ref; out_cmd && !frc_q |=> rsp_status == RESP_REFUSED; endproperty
	a_ref: assert property (p_ref) else $error("output command not refused");
	property p_out; out_cmd && frc_q |=> rsp_status == RESP_OK; endproperty
	a_out: assert property (p_out) else $error("output command refused in forced mode");
	property p_cur;
		req_valid && req_cmd == CMD_RD_ALARM && req_dn == DN_ZERO |=>
			rsp_status == RESP_OK && rsp_data[31:16] == 16'h0000;
	endproperty
	a_cur: assert property (p_cur) else $error("current alarm too wide");
	property p_det;
		req_valid && req_cmd == CMD_RD_ALARM && req_dn == DN_ALM_DET |=>
			rsp_data[31:16] != NO_ALARM || rsp_data[15:0] == 16'h0000;
	endproperty
	a_det: assert property (p_det) else $error("detail given with no alarm");
	property p_hist;
		req_valid && req_cmd == CMD_RD_HIST && req_dn < 8'h30 |=>
			rsp_status == RESP_OK && rsp_data[31:16] == 16'h0000;
	endproperty
	a_hist: assert property (p_hist) else $error("history answer bad");
	property p_snap;
		req_valid && req_cmd == CMD_RD_SNAP |=> rsp_status == (snap_in ? RESP_OK : RESP_BAD);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot status wrong");
	c_sel: cover property (sel_do);
	c_out: cover property (out_cmd && frc_q);
	c_clr: cover property (req_valid && req_cmd == CMD_CLEAR);
endmodule

// ---- dv/servo_diag_command_handler_bench.sv ----
// Self-checking bench joining master and slave ends over the link
`timescale 1ns/100ps
module servo_diag_command_handler_bench;
	import diag_pkg::*;
	localparam logic [31:0] VER = 32'h0000_5A3C; // Arbitrary value
	logic clk_sys, nrst, user_valid, user_ready, ans_valid, alarm_event, alarm_clear_input;
	logic forced_mode, inputs_disabled, stop_lock;
	logic [7:0] user_cmd, user_dn;
	logic [31:0] user_data, ans_data, pos_pulse, pos_unit, rd;
	logic [1:0] ans_status, st;
	logic [15:0] alarm_num, alarm_detail, run_hours, active_alarm;
	logic [31:0] snap_word [SNAP_ITEMS];
	logic [31:0] cap [SNAP_ITEMS];
	logic [OUT_PINS-1:0] io_connector;
	int hn[16], hd[16], hh[16];
	int act, adet, n_fail, checks, n_clr, v;
	diag_if lnk();
	diag_master i_diag_master(.clk_sys(clk_sys), .nrst(nrst), .link(lnk), .user_valid(user_valid),
		.user_cmd(user_cmd), .user_dn(user_dn), .user_data(user_data), .user_ready(user_ready),
		.ans_valid(ans_valid), .ans_data(ans_data), .ans_status(ans_status));
	// Short watchdog keeps the silence test brief
	diag_slave #(.WDOG_CYCLES(20), .VERSION_WORD(VER)) i_diag_slave(.clk_sys(clk_sys),
		.nrst(nrst), .link(lnk), .alarm_event(alarm_event), .alarm_num(alarm_num),
		.alarm_detail(alarm_detail), .run_hours(run_hours), .snap_word(snap_word),
		.pos_pulse(pos_pulse), .pos_unit(pos_unit), .io_connector(io_connector),
		.forced_mode(forced_mode), .inputs_disabled(inputs_disabled),
		.alarm_clear_input(alarm_clear_input), .stop_lock(stop_lock), .active_alarm(active_alarm));
	servo_diag_command_handler_asserts i_chk(.clk_sys(clk_sys), .nrst(nrst),
		.req_valid(lnk.req_valid), .req_cmd(lnk.req_cmd), .req_dn(lnk.req_dn),
		.req_data(lnk.req_data), .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data),
		.rsp_status(lnk.rsp_status));
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Count clear pulses, a one-cycle output easily missed by polling
	always @(posedge clk_sys) if (alarm_clear_input === 1'b1) n_clr++;
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// One user request; waits bounded for ready and for the answer
	task automatic rq(input logic [7:0] c, input logic [7:0] d, input logic [31:0] x);
		int k;
		k = 0;
		while (user_ready !== 1'b1 && k < 50) begin
			@(negedge clk_sys);
			k++;
		end
		// A master that never comes ready is a hang, not a pass
		if (user_ready !== 1'b1) begin
			$display("[FAIL] user_ready timeout");
			n_fail++;
			results();
		end
		user_valid = 1;
		user_cmd = c;
		user_dn = d;
		user_data = x;
		@(negedge clk_sys);
		user_valid = 0;
		k = 0;
		while (ans_valid !== 1'b1 && k < 50) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		if (ans_valid !== 1'b1) begin
			$display("[FAIL] ans_valid timeout");
			n_fail++;
			results();
		end
		rd = ans_data;
		st = ans_status;
		@(negedge clk_sys);
	endtask
	// Raise an alarm and push the model history
	task automatic al(input int n, input int d, input int h);
		alarm_event = 1;
		alarm_num = n[15:0];
		alarm_detail = d[15:0];
		run_hours = h[15:0];
		@(negedge clk_sys);
		alarm_event = 0;
		for (int i = 15; i > 0; i--) begin
			hn[i] = hn[i-1];
			hd[i] = hd[i-1];
			hh[i] = hh[i-1];
		end
		hn[0] = n;
		hd[0] = d;
		hh[0] = h;
		act = n;
		adet = d;
		foreach (cap[i]) cap[i] = snap_word[i];
		// Idle edge keeps the strobe from being lowered and raised in one step
		@(negedge clk_sys);
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		void'($urandom(32'h14B9));
		{nrst, user_valid, alarm_event, user_cmd, user_dn, user_data} = '0;
		{alarm_num, alarm_detail, run_hours} = '0;
		pos_pulse = $urandom;
		pos_unit = $urandom;
		foreach (snap_word[i]) snap_word[i] = '0;
		foreach (hn[i]) {hn[i], hd[i], hh[i]} = {32'hFF, 64'h0};
		act = 255;
		repeat (6) @(negedge clk_sys);
		nrst = 1;
		@(negedge clk_sys);
		rq(CMD_RD_ALARM, DN_ZERO, 0);
		chk("cur", rd, 32'h0000_00FF);
		rq(CMD_RD_ALARM, DN_ALM_DET, 0);
		chk("curdet", rd, NO_ALARM_DET);
		rq(CMD_OUT_SET, DN_OUT_PINS, 32'h0000_01FF);
		chk("refst", st, 1);
		chk("refpin", io_connector, 0);
		rq(CMD_TEST, DN_ZERO, TEST_DO);
		chk("indis", inputs_disabled, 1);
		chk("forced", forced_mode, 1);
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			rq(CMD_OUT_SET, DN_OUT_PINS, v);
			chk("pins", io_connector, v[8:0]);
			chk("pinst", st, 0);
		end
		chk("nolock", stop_lock, 0);
		repeat (30) @(negedge clk_sys);
		chk("lock", stop_lock, 1);
		rq(CMD_TEST, DN_ZERO, TEST_OFF);
		@(negedge clk_sys);
		chk("off", forced_mode, 0);
		chk("offpin", io_connector, 0);
		chk("unlock", stop_lock, 0);
		rq(CMD_IN_DIS, DN_IN_EN, KEY_1EA5);
		chk("inen", inputs_disabled, 0);
		rq(CMD_IN_DIS, DN_IN_DIS, 32'h0000_0000);
		chk("inkey", inputs_disabled, 0);
		// Other test modes count as test operation but never force pins
		rq(CMD_TEST, DN_ZERO, 32'h0000_0001);
		chk("jog", forced_mode, 0);
		rq(CMD_OUT_SET, DN_OUT_PINS, 32'h0000_0155);
		chk("jogref", st, 1);
		chk("jogpin", io_connector, 0);
		rq(CMD_TEST, DN_ZERO, TEST_OFF);
		rq(CMD_RD_ALARM, 8'h01, 0);
		chk("badst", st, 2);
		chk("baddat", rd, 0);
		for (int i = 0; i < 18; i++) begin
			if (i == 17) foreach (snap_word[j]) snap_word[j] = $urandom;
			al($urandom_range(1, 254), $urandom_range(0, 65535), $urandom_range(0, 65535));
		end
		foreach (snap_word[j]) snap_word[j] = ~snap_word[j];
		chk("act", active_alarm, act);
		// History is read only while no alarm is raised
		for (int i = 0; i < 16; i++) begin
			rq(CMD_RD_HIST, 8'(i), 0);
			chk("hnum", rd, hn[i]);
			rq(CMD_RD_HIST, 8'(32 + i), 0);
			chk("hhrs", rd, hh[i]);
			rq(CMD_RD_HIST, 8'(64 + i), 0);
			chk("hdet", rd, hd[i]);
		end
		rq(CMD_RD_ALARM, DN_ALM_DET, 0);
		chk("curdet", rd, {act[15:0], adet[15:0]});
		for (int i = 0; i < SNAP_ITEMS; i++) begin
			rq(CMD_RD_SNAP, (i < 15) ? 8'(128 + i) : 8'(160 + i - 15), 0);
			chk("snap", rd, cap[i]);
		end
		rq(CMD_RD_SNAP, 8'h8F, 0);
		chk("snapbad", st, 2);
		rq(CMD_RD_ALARM, DN_VERSION, 0);
		chk("ver", rd, VER);
		rq(CMD_RD_ALARM, DN_POS_PULSE, 0);
		chk("pospls", rd, pos_pulse);
		rq(CMD_RD_ALARM, DN_POS_UNIT, 0);
		chk("posunit", rd, pos_unit);
		rq(CMD_CLEAR, DN_ZERO, KEY_1EA5);
		chk("rstalm", active_alarm, 16'h00FF);
		chk("clrpulse", n_clr, 1);
		// A wrong key must leave the history alone
		rq(CMD_CLEAR, DN_HIST_CLR, 32'h0000_1EA4);
		rq(CMD_RD_HIST, 8'h00, 0);
		chk("hkeep", rd, hn[0]);
		rq(CMD_CLEAR, DN_HIST_CLR, KEY_1EA5);
		for (int i = 0; i < 16; i++) begin
			rq(CMD_RD_HIST, 8'(i), 0);
			chk("hclr", rd, 32'h0000_00FF);
			rq(CMD_RD_HIST, 8'(64 + i), 0);
			chk("hdclr", rd, 0);
		end
		results();
	end
endmodule
